//--- piu_defines.vh
// How it works
// - a quick input latches a short ON pulse into its status bit for one scan
// - any ON pulse of 30 us or more is caught on a quick input
// - a latched short pulse is cleared at the next I/O refresh
// - on an interrupt the cyclic program pauses, the task runs, then resumes
// - input 0 to 7 start fixed tasks 140 to 147
// - direct mode asks for the task on each selected edge
// - counter mode counts edges; up to the set value or down to zero
// - counters are 16 bits, set values 0001 to FFFF hex
// - all eight inputs count 3 kHz single-phase pulses at once
// - the visible present value refreshes every scan and at task start
// - edge setup applies at program-to-run; codes 110-117 override it
// - codes 100-107 pick direct or counter, up or down, and enable
// - while globally disabled, counters keep counting but start no task
// - each input may latch a pulse output or counter value at task start
// - latched values kept as lower and upper 16-bit words per input
`ifndef PIU_DEFINES_VH
`define PIU_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PIU_OFS_STAT0 8'h00
`define PIU_OFS_STAT1 8'h04
`define PIU_OFS_QUICK 8'h08
`define PIU_OFS_EDGE 8'h0C
`define PIU_OFS_LSEL 8'h10
`define PIU_OFS_MCMD 8'h14
`define PIU_OFS_GCTL 8'h18
`define PIU_OFS_ISTAT 8'h1C
`define PIU_OFS_IMASK 8'h20
`define PIU_OFS_CHST 8'h24
`define PIU_OFS_SV_PAGE 3'b010
`define PIU_OFS_PV_PAGE 3'b011
`define PIU_OFS_LAT_PAGE 2'b10

// ----------------------------------------
// command codes, task numbers, fields
// ----------------------------------------
`define PIU_CODE_MODE 8'd100
`define PIU_CODE_EDGE 8'd110
`define PIU_TASK_BASE 8'd140
`define PIU_CMD_DIRECT 2'd0
`define PIU_CMD_DISABLE 2'd1
`define PIU_CMD_UP 2'd2
`define PIU_CMD_DOWN 2'd3
`define PIU_SEL_PULSE 4'd1
`define PIU_SEL_HSC 4'd5
`define PIU_SEL_LAST 4'd8

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define PIU_RST_SV 16'h0001
`define PIU_RST_WORD 32'h0000_0000
`define PIU_CLK_KHZ 25000
`define PIU_MIN_PULSE_NS 30000
`define PIU_MIN_PULSE_CYC ((`PIU_MIN_PULSE_NS * `PIU_CLK_KHZ + 999999) / 1000000)
`define PIU_CNT_HZ 3000

`endif

//--- piu_top.v
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "piu_defines.vh"

module piu_top (
   input wire clk_i,
   input wire nrst_i,
   input wire [7:0] field_input_i,
   input wire refresh_i,
   input wire run_mode_i,
   input wire task_done_i,
   input wire [127:0] pulse_pv_i,
   input wire [127:0] hsc_pv_i,
   output reg task_run_o,
   output reg [7:0] task_num_o,
   output reg irq_o,
   input wire [7:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output reg s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output reg s_axi_wready_o,
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [7:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output reg s_axi_arready_o,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   reg rst_a_r, rst_n_r;

   // two stages so release never races the clock
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_a_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_n_r <= rst_a_r;
      end
   end

   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg [7:0] s1_r, s2_r, s3_r, lvl_r, prev_r, qpend_r, qstat_r, istat_r, imask_r, aw_a_r;
   reg [7:0] quick_r, edge_set_r, edge_r, en_r, cmode_r, down_r, pend_r;
   reg [31:0] lsel_r, w_d_r, mcmd_r, lat_val, rd_val;
   reg [15:0] sv_r [0:7];
   reg [15:0] cnt_r [0:7];
   reg [15:0] pv_r [0:7];
   reg [31:0] lat_r [0:7];
   reg [3:0] w_s_r, sel;
   reg [2:0] pick;
   reg gie_r, busy_r, run_prev_r, aw_f_r, w_f_r, rd_ok;
   integer i, k;

   wire [7:0] rise = lvl_r & ~prev_r;
   wire [7:0] fall = ~lvl_r & prev_r;
   wire [7:0] hit = (rise & ~edge_r) | (fall & edge_r);
   wire wr_go = aw_f_r & w_f_r & ~s_axi_bvalid_o;
   wire wr_full = wr_go & (w_s_r != 4'h0);
   wire wr_cmd = wr_full & (aw_a_r == `PIU_OFS_MCMD);
   wire [7:0] code = w_d_r[7:0];
   wire [1:0] cval = w_d_r[17:16];
   wire is_mode = (code >= `PIU_CODE_MODE) && (code < `PIU_CODE_MODE + 8'd8);
   wire is_edge = (code >= `PIU_CODE_EDGE) && (code < `PIU_CODE_EDGE + 8'd8);
   wire [7:0] mdiff = code - `PIU_CODE_MODE, ediff = code - `PIU_CODE_EDGE;
   wire [2:0] mch = mdiff[2:0], ech = ediff[2:0];
   wire start = ~busy_r & gie_r & (pend_r != 8'h00);
   wire run_go = run_mode_i & ~run_prev_r;
   wire b_wait = s_axi_bvalid_o & ~s_axi_bready_i; // write answer not yet taken

   // lowest pending input wins when several ask at once
   always @* begin
      pick = 3'd0;
      for (k = 7; k >= 0; k = k - 1) begin
         if (pend_r[k]) begin
            pick = k[2:0];
         end
      end
   end

   // value to latch for the chosen input's selector
   always @* begin
      sel = lsel_r[pick*4 +: 4];
      lat_val = lat_r[pick];
      if (sel >= `PIU_SEL_PULSE && sel < `PIU_SEL_HSC) begin
         lat_val = pulse_pv_i[(sel - `PIU_SEL_PULSE)*32 +: 32];
      end else if (sel >= `PIU_SEL_HSC && sel <= `PIU_SEL_LAST) begin
         lat_val = hsc_pv_i[(sel - `PIU_SEL_HSC)*32 +: 32];
      end
   end

   // ----------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------
   // a level is taken only once stages two and three agree, so one glitch
   // near a clock edge cannot produce two edges
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s1_r <= 8'h00;
         s2_r <= 8'h00;
         s3_r <= 8'h00;
         lvl_r <= 8'h00;
         prev_r <= 8'h00;
      end else begin
         s1_r <= field_input_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
         prev_r <= lvl_r;
      end
   end

   // ----------------------------------------
   // quick-response status
   // ----------------------------------------
   // sampling every 40 ns catches any pulse of two clocks (80 ns) or more, far shorter than 30 us
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         qpend_r <= 8'h00;
         qstat_r <= 8'h00;
      end else if (refresh_i) begin
         qstat_r <= lvl_r | (qpend_r & quick_r);
         qpend_r <= rise & quick_r;
      end else begin
         qpend_r <= qpend_r | (rise & quick_r);
      end
   end

   // ----------------------------------------
   // per-input mode, edge, counters, requests
   // ----------------------------------------
   // one edge per input per clock: 3 kHz on all inputs at once is trivial
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         edge_r <= 8'h00;
         en_r <= 8'h00;
         cmode_r <= 8'h00;
         down_r <= 8'h00;
         pend_r <= 8'h00;
         run_prev_r <= 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            cnt_r[i] <= 16'h0000;
         end
      end else begin
         run_prev_r <= run_mode_i;
         if (start) begin
            pend_r[pick] <= 1'b0;
         end
         if (run_go) begin
            edge_r <= edge_set_r;
         end
         for (i = 0; i < 8; i = i + 1) begin
            if (en_r[i] && hit[i]) begin
               if (!cmode_r[i]) begin
                  pend_r[i] <= 1'b1;
               end else if (!down_r[i]) begin
                  if (cnt_r[i] + 16'h0001 == sv_r[i]) begin
                     cnt_r[i] <= 16'h0000;
                     if (gie_r) begin
                        pend_r[i] <= 1'b1;
                     end
                  end else begin
                     cnt_r[i] <= cnt_r[i] + 16'h0001;
                  end
               end else begin
                  if (cnt_r[i] == 16'h0001) begin
                     cnt_r[i] <= sv_r[i];
                     if (gie_r) begin
                        pend_r[i] <= 1'b1;
                     end
                  end else begin
                     cnt_r[i] <= cnt_r[i] - 16'h0001;
                  end
               end
            end
         end
         // a down command reloads the count from the new set value, which is how a set
         // value change takes effect there; up counting compares against it directly
         if (wr_cmd && is_mode) begin
            case (cval)
               `PIU_CMD_DIRECT: begin
                  en_r[mch] <= 1'b1;
                  cmode_r[mch] <= 1'b0;
               end
               `PIU_CMD_DISABLE: begin
                  en_r[mch] <= 1'b0;
                  pend_r[mch] <= 1'b0;
               end
               `PIU_CMD_UP: begin
                  en_r[mch] <= 1'b1;
                  cmode_r[mch] <= 1'b1;
                  down_r[mch] <= 1'b0;
                  cnt_r[mch] <= 16'h0000;
               end
               default: begin
                  en_r[mch] <= 1'b1;
                  cmode_r[mch] <= 1'b1;
                  down_r[mch] <= 1'b1;
                  cnt_r[mch] <= sv_r[mch];
               end
            endcase
         end
         if (wr_cmd && is_edge) begin
            edge_r[ech] <= cval[0];
         end
      end
   end

   // ----------------------------------------
   // task scheduling, latch and visible value
   // ----------------------------------------
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         busy_r <= 1'b0;
         task_run_o <= 1'b0;
         task_num_o <= `PIU_TASK_BASE;
         for (i = 0; i < 8; i = i + 1) begin
            pv_r[i] <= 16'h0000;
            lat_r[i] <= `PIU_RST_WORD;
         end
      end else begin
         if (refresh_i) begin
            for (i = 0; i < 8; i = i + 1) begin
               pv_r[i] <= cnt_r[i];
            end
         end
         if (start) begin
            busy_r <= 1'b1;
            task_run_o <= 1'b1;
            task_num_o <= `PIU_TASK_BASE + {5'b00000, pick};
            pv_r[pick] <= cnt_r[pick];
            lat_r[pick] <= lat_val;
         end else if (busy_r && task_done_i) begin
            busy_r <= 1'b0;
            task_run_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // software interrupt status
   // ----------------------------------------
   // a task start in the clearing cycle survives: set beats clear
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         istat_r <= 8'h00;
         irq_o <= 1'b0;
      end else begin
         irq_o <= (istat_r & imask_r) != 8'h00;
         if (wr_full && aw_a_r == `PIU_OFS_ISTAT) begin
            istat_r <= (istat_r & ~w_d_r[7:0]) | ({7'h00, start} << pick);
         end else begin
            istat_r <= istat_r | ({7'h00, start} << pick);
         end
      end
   end

   // ----------------------------------------
   // bus write side
   // ----------------------------------------
   wire w_known = (aw_a_r <= `PIU_OFS_CHST && aw_a_r[1:0] == 2'b00) ||
      (aw_a_r[7:5] == `PIU_OFS_SV_PAGE && aw_a_r[1:0] == 2'b00);
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aw_f_r <= 1'b0;
         w_f_r <= 1'b0;
         aw_a_r <= 8'h00;
         w_d_r <= `PIU_RST_WORD;
         w_s_r <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= 2'b00;
         quick_r <= 8'h00;
         edge_set_r <= 8'h00;
         lsel_r <= `PIU_RST_WORD;
         mcmd_r <= `PIU_RST_WORD;
         gie_r <= 1'b0;
         imask_r <= 8'h00;
         for (i = 0; i < 8; i = i + 1) begin
            sv_r[i] <= `PIU_RST_SV;
         end
      end else begin
         s_axi_awready_o <= ~aw_f_r & ~b_wait & ~(s_axi_awvalid_i & s_axi_awready_o);
         s_axi_wready_o <= ~w_f_r & ~b_wait & ~(s_axi_wvalid_i & s_axi_wready_o);
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_f_r <= 1'b1;
            aw_a_r <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_f_r <= 1'b1;
            w_d_r <= s_axi_wdata_i;
            w_s_r <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_f_r <= 1'b0;
            w_f_r <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= w_known ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
         if (wr_full) begin
            case (aw_a_r)
               `PIU_OFS_QUICK: quick_r <= w_d_r[7:0];
               `PIU_OFS_EDGE: edge_set_r <= w_d_r[7:0];
               `PIU_OFS_LSEL: lsel_r <= w_d_r;
               `PIU_OFS_MCMD: mcmd_r <= w_d_r;
               `PIU_OFS_GCTL: gie_r <= w_d_r[0];
               `PIU_OFS_IMASK: imask_r <= w_d_r[7:0];
               default: begin
                  if (aw_a_r[7:5] == `PIU_OFS_SV_PAGE) begin
                     sv_r[aw_a_r[4:2]] <= w_d_r[15:0];
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // bus read side
   // ----------------------------------------
   // read word picked from the address as it stands on the bus
   always @* begin
      rd_val = `PIU_RST_WORD;
      rd_ok = 1'b1;
      case (s_axi_araddr_i)
         `PIU_OFS_STAT0: rd_val = {28'h000_0000, qstat_r[3:0]};
         `PIU_OFS_STAT1: rd_val = {28'h000_0000, qstat_r[7:4]};
         `PIU_OFS_QUICK: rd_val = {24'h00_0000, quick_r};
         `PIU_OFS_EDGE: rd_val = {24'h00_0000, edge_set_r};
         `PIU_OFS_LSEL: rd_val = lsel_r;
         `PIU_OFS_MCMD: rd_val = mcmd_r;
         `PIU_OFS_GCTL: rd_val = {30'h0, busy_r, gie_r};
         `PIU_OFS_ISTAT: rd_val = {24'h00_0000, istat_r};
         `PIU_OFS_IMASK: rd_val = {24'h00_0000, imask_r};
         `PIU_OFS_CHST: rd_val = {edge_r, down_r, cmode_r, en_r};
         default: begin
            if (s_axi_araddr_i[1:0] != 2'b00) begin
               rd_ok = 1'b0;
            end else if (s_axi_araddr_i[7:5] == `PIU_OFS_SV_PAGE) begin
               rd_val = {16'h0000, sv_r[s_axi_araddr_i[4:2]]};
            end else if (s_axi_araddr_i[7:5] == `PIU_OFS_PV_PAGE) begin
               rd_val = {16'h0000, pv_r[s_axi_araddr_i[4:2]]};
            end else if (s_axi_araddr_i[7:6] == `PIU_OFS_LAT_PAGE) begin
               if (s_axi_araddr_i[2]) begin
                  rd_val = {16'h0000, lat_r[s_axi_araddr_i[5:3]][31:16]};
               end else begin
                  rd_val = {16'h0000, lat_r[s_axi_araddr_i[5:3]][15:0]};
               end
            end else begin
               rd_ok = 1'b0;
            end
         end
      endcase
   end

   // one read in flight; address is taken only while no answer waits
   always @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= `PIU_RST_WORD;
         s_axi_rresp_o <= 2'b00;
      end else begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_val;
            s_axi_rresp_o <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid_o) begin
            if (s_axi_rready_i) begin
               s_axi_rvalid_o <= 1'b0;
               s_axi_arready_o <= 1'b1;
            end
         end else begin
            s_axi_arready_o <= 1'b1;
         end
      end
   end

endmodule // piu_top
`default_nettype wire

//--- piu_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module piu_top_checker (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic task_done_i,
   input wire logic task_run_o,
   input wire logic [7:0] task_num_o,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o
);
   // ----
   // one domain, so clock and reset are given once
   // ----
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // both write halves taken at one edge, then the answer
   sequence s_wr_take;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   // a task that runs and has not been told it is done
   sequence s_task_open;
      task_run_o && !task_done_i;
   endsequence

   a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid_o)
      else $error("write response missing");
   a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
   a_b_blocks: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken during response");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
      else $error("read data late");
   a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
   a_r_blocks: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken during data");
   a_task_range: assert property (task_run_o |-> task_num_o >= 8'd140 && task_num_o <= 8'd147)
      else $error("task number out of range");
   a_task_hold: assert property (s_task_open |=> task_run_o && $stable(task_num_o))
      else $error("task ended early");
   a_task_end: assert property (task_run_o && task_done_i |=> !task_run_o)
      else $error("task kept running");
   c_task: cover property (task_run_o && task_done_i);
endmodule // piu_top_checker
`default_nettype wire

//--- piu_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module piu_field_model (
   input wire logic clk_i,
   output logic [7:0] field_o
);
   // pins idle low, always driven by the field wiring
   initial field_o = 8'h00;
   // edges land just after a clock edge, then the level holds
   task automatic drive(input logic [7:0] msk, input logic lvl, input int hold);
      @(posedge clk_i);
      field_o <= lvl ? (field_o | msk) : (field_o & ~msk);
      repeat (hold) @(posedge clk_i);
   endtask
endmodule // piu_field_model
`default_nettype wire

//--- pulse_input_interrupt_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_input_interrupt_unit_tb_top;
   logic clk_i = 1'b0, nrst_i = 1'b0, refresh_i = 1'b0, run_mode_i = 1'b0, task_done_i = 1'b0;
   logic [127:0] pulse_pv_i = 128'h0, hsc_pv_i = 128'h0;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0000_0000;
   logic [3:0] s_axi_wstrb_i = 4'hf;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   wire task_run_o, irq_o, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   wire s_axi_arready_o, s_axi_rvalid_o;
   wire [7:0] task_num_o, field_input_i;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire [31:0] s_axi_rdata_o;
   int n_errors = 0, num_checks = 0, i, done_cnt = 0;
   logic run_d = 1'b0;
   logic [31:0] pv_a, pv_b;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [7:0] tq[$];

   always #20 clk_i = ~clk_i;

   piu_field_model fld_u (.clk_i(clk_i), .field_o(field_input_i));
   piu_top dut_u (.clk_i, .nrst_i, .field_input_i, .refresh_i, .run_mode_i, .task_done_i,
      .pulse_pv_i, .hsc_pv_i, .task_run_o, .task_num_o, .irq_o, .s_axi_awaddr_i,
      .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
      .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
      .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
      .s_axi_rready_i);

   // ----
   // reporting
   // ----
   task automatic end_sim();
      if (n_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo();
      n_errors++;
      end_sim();
   endtask

   // ----
   // bus master; expected answers go to the queues first
   // ----
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      bq.push_back(r);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o) break;
      end
      s_axi_bready_i <= 1'b0;
      if (n == 100) tmo();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      rq.push_back({r, d});
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o) break;
      end
      s_axi_rready_i <= 1'b0;
      if (n == 100) tmo();
   endtask
   task automatic cmd(input int code, input logic [1:0] v);
      wr(8'h14, {14'h0, v, 8'h00, 8'(code)}, 2'b00);
   endtask
   task automatic ed(input logic [7:0] m, input logic l);
      fld_u.drive(m, l, 40);
   endtask
   task automatic refr();
      @(posedge clk_i);
      refresh_i <= 1'b1;
      @(posedge clk_i);
      refresh_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask

   // watcher: each answer or task start takes the oldest note; finished tasks are acked
   always @(posedge clk_i) begin
      run_d <= task_run_o;
      task_done_i <= (done_cnt == 1);
      if (done_cnt > 0) done_cnt <= done_cnt - 1;
      if (s_axi_rvalid_o && s_axi_rready_i)
         chk({s_axi_rresp_o, s_axi_rdata_o}, rq.size() ? rq.pop_front() : 34'bx);
      if (s_axi_bvalid_o && s_axi_bready_i)
         chk(34'(s_axi_bresp_o), bq.size() ? 34'(bq.pop_front()) : 34'bx);
      if (task_run_o && !run_d) begin
         chk(34'(task_num_o), tq.size() ? 34'(tq.pop_front()) : 34'bx);
         done_cnt <= 4;
      end
   end

   // ----
   // main sequence
   // ----
   initial begin
      void'($urandom(99));
      pv_a = $urandom;
      pv_b = $urandom;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      pulse_pv_i <= {96'h0, pv_a};
      hsc_pv_i <= {64'h0, pv_b, 32'h0000_0000};
      rd(8'h40, 32'h0000_0001, 2'b00);
      rd(8'hf0, 32'h0000_0000, 2'b10);
      wr(8'hf4, 32'h0000_0001, 2'b10);
      wr(8'h0c, 32'h0000_0008, 2'b00);
      @(posedge clk_i);
      run_mode_i <= 1'b1;
      wr(8'h10, 32'h0000_0061, 2'b00);
      wr(8'h20, 32'h0000_00ff, 2'b00);
      wr(8'h18, 32'h0000_0001, 2'b00);
      for (i = 0; i < 8; i++) cmd(100 + i, 2'd0);
      // input 3 fires on its falling edge only
      for (i = 0; i < 8; i++) begin
         if (i != 3) tq.push_back(8'(140 + i));
         ed(8'h01 << i, 1'b1);
         if (i == 3) tq.push_back(8'd143);
         ed(8'h01 << i, 1'b0);
      end
      @(negedge clk_i);
      chk(34'(irq_o), 34'h1);
      rd(8'h1c, 32'h0000_00ff, 2'b00);
      rd(8'h80, {16'h0, pv_a[15:0]}, 2'b00);
      rd(8'h84, {16'h0, pv_a[31:16]}, 2'b00);
      rd(8'h88, {16'h0, pv_b[15:0]}, 2'b00);
      rd(8'h8c, {16'h0, pv_b[31:16]}, 2'b00);
      wr(8'h1c, 32'h0000_00ff, 2'b00);
      wr(8'h20, 32'h0000_0000, 2'b00);
      // edge override to rising, with the interrupt masked out
      cmd(113, 2'd0);
      tq.push_back(8'd143);
      ed(8'h08, 1'b1);
      ed(8'h08, 1'b0);
      @(negedge clk_i);
      chk(34'(irq_o), 34'h0);
      // input 2 overridden to its falling edge, then back to rising
      cmd(112, 2'd1);
      ed(8'h04, 1'b1);
      tq.push_back(8'd142);
      ed(8'h04, 1'b0);
      cmd(112, 2'd0);
      wr(8'h20, 32'h0000_0008, 2'b00);
      @(negedge clk_i);
      chk(34'(irq_o), 34'h1);
      wr(8'h1c, 32'h0000_0008, 2'b00);
      @(negedge clk_i);
      chk(34'(irq_o), 34'h0);
      // all eight count together at 3 kHz; even up, odd down, set value 3
      for (i = 0; i < 8; i++) begin
         cmd(100 + i, 2'd1);
         wr(8'(8'h40 + 4 * i), 32'h0000_0003, 2'b00);
         cmd(100 + i, i[0] ? 2'd3 : 2'd2);
      end
      repeat (2) begin
         fld_u.drive(8'hff, 1'b1, 4166);
         fld_u.drive(8'hff, 1'b0, 4166);
      end
      for (i = 0; i < 8; i++) tq.push_back(8'(140 + i));
      fld_u.drive(8'hff, 1'b1, 4166);
      fld_u.drive(8'hff, 1'b0, 200);
      chk(34'(tq.size()), 34'h0);
      refr();
      rd(8'h60, 32'h0000_0000, 2'b00);
      rd(8'h64, 32'h0000_0003, 2'b00);
      // globally disabled: counting goes on, no task starts
      wr(8'h18, 32'h0000_0000, 2'b00);
      ed(8'h01, 1'b1);
      ed(8'h01, 1'b0);
      refr();
      rd(8'h60, 32'h0000_0001, 2'b00);
      repeat (2) begin
         ed(8'h01, 1'b1);
         ed(8'h01, 1'b0);
      end
      wr(8'h18, 32'h0000_0001, 2'b00);
      repeat (20) @(posedge clk_i);
      chk(34'(tq.size()), 34'h0);
      // quick input 6: 30 us pulse, seen at one refresh, gone at the next
      cmd(106, 2'd1);
      wr(8'h08, 32'h0000_0040, 2'b00);
      fld_u.drive(8'h40, 1'b1, 750);
      ed(8'h40, 1'b0);
      refr();
      rd(8'h04, 32'h0000_0004, 2'b00);
      refr();
      rd(8'h04, 32'h0000_0000, 2'b00);
      repeat (20) @(posedge clk_i);
      chk(34'(tq.size()), 34'h0);
      end_sim();
   end
endmodule // pulse_input_interrupt_unit_tb_top

bind piu_top piu_top_checker chk_u (.clk_i, .nrst_i, .task_done_i, .task_run_o, .task_num_o,
   .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
   .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .s_axi_rdata_o);
`default_nettype wire
